// *** card_interface_sequencer.sv ***
/*
 * card interface sequencer: state machine, supply gating, data channel
 * arbitration, fault checks, card switch debounce, ahb-lite status.
 * assumes the analog supply reports under-range and ready levels on
 * plain inputs and that all pins are synchronous to i_mclk.
 */
// How it works
// - power request low enters active, supply on
// - clock and reset held until ready
// - data channels need ready and select
// - voltage select latched at request fall
// - disabled channels in active: card high, host released
// - early select still waits for ready
// - select never touches supply, clock, reset
// - polarity input sets switch active level
// - supply under-range held 5 us forces alarm
// - idle and alarm discharge card supply
// - idle card data pin pulled low
// - idle card clock and reset low
// - first low side becomes input
// - no transfer from output back
// - input release returns channel idle
// - stuck low on output not passed
// - direction chosen only from idle
// - reset mismatch after ready forces alarm
// - reduced variant ties select, normally open
// - clock mismatch after ready forces alarm
// - alarm cleared only by request high
// - fault output low in alarm
// - presence debounced, removal reported fast
`timescale 1ns/100ps
`default_nettype none

// ************************************************************
// one half-duplex channel arbiter
// ************************************************************
module chan_arbiter (
	// clock and reset
	input  wire logic                      i_mclk,
	input  wire logic                      i_rst_n,
	// control
	input  wire logic                      i_enable,
	input  wire logic                      i_idle_low,
	// pins
	input  wire card_seq_pkg::chan_sense_t i_sense,
	output card_seq_pkg::chan_drive_t      o_drive
);
	typedef struct packed {
		card_seq_pkg::dir_t dir;
		logic               armed;
	} st_t;
	st_t s_q;
	st_t s_d;

	always_comb begin
		s_d = s_q;
		s_d.armed = 1'b0;
		if (!i_enable) begin
			s_d.dir = card_seq_pkg::DIR_IDLE;
		end else begin
			case (s_q.dir)
				card_seq_pkg::DIR_IDLE: begin
					// a low left standing after a transfer must clear
					// before the channel may take a new direction
					s_d.armed = i_sense.host_in && i_sense.card_in;
					if (s_q.armed && !i_sense.host_in)
						s_d.dir = card_seq_pkg::DIR_H2C;
					else if (s_q.armed && !i_sense.card_in)
						s_d.dir = card_seq_pkg::DIR_C2H;
				end
				card_seq_pkg::DIR_H2C: begin
					if (i_sense.host_in)
						s_d.dir = card_seq_pkg::DIR_IDLE;
				end
				card_seq_pkg::DIR_C2H: begin
					if (i_sense.card_in)
						s_d.dir = card_seq_pkg::DIR_IDLE;
				end
				default: s_d.dir = card_seq_pkg::DIR_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n)
			s_q <= '{dir: card_seq_pkg::DIR_IDLE, armed: 1'b0};
		else
			s_q <= s_d;
	end

	// while enabled, only the output side is pulled; input side stays released
	always_comb begin
		o_drive.host_o  = 1'b0;
		o_drive.host_oe = 1'b0;
		o_drive.card_o  = 1'b1;
		o_drive.card_oe = 1'b1;
		if (i_idle_low) begin
			o_drive.card_o  = 1'b0;
		end else if (i_enable) begin
			o_drive.card_oe = 1'b0;
			if (s_q.dir == card_seq_pkg::DIR_H2C) begin
				o_drive.card_o  = 1'b0;
				o_drive.card_oe = 1'b1;
			end else if (s_q.dir == card_seq_pkg::DIR_C2H)
				o_drive.host_oe = 1'b1;
		end
	end

	a_back_block: assert property (@(posedge i_mclk)
		disable iff (!i_rst_n)
		s_q.dir == card_seq_pkg::DIR_H2C |-> !o_drive.host_oe)
		else $error("output side drove input side");
	a_dir_from_idle: assert property (@(posedge i_mclk)
		disable iff (!i_rst_n)
		(s_q.dir == card_seq_pkg::DIR_H2C)
		|=> s_q.dir != card_seq_pkg::DIR_C2H)
		else $error("direction flipped without idle");
	a_stuck_low: assert property (@(posedge i_mclk)
		disable iff (!i_rst_n)
		s_q.dir == card_seq_pkg::DIR_IDLE && !s_q.armed
		|=> s_q.dir == card_seq_pkg::DIR_IDLE)
		else $error("direction taken before both sides were high");
endmodule // chan_arbiter

// ************************************************************
// top level
// ************************************************************
module card_interface_sequencer #(
	parameter int DEBOUNCE_CYC = card_seq_pkg::DEBOUNCE_CYC,
	parameter int RAMP_CYC     = card_seq_pkg::RAMP_CYC_DEF
) (
	// clock and reset
	input  wire logic        i_mclk,
	input  wire logic        i_rst_n,
	// host side controls
	input  wire logic        i_power_request_n,
	input  wire logic        i_io_select_n,
	input  wire logic        i_voltage_select,
	input  wire logic        i_switch_polarity,
	input  wire logic        i_host_reset_in,
	input  wire logic        i_host_clock_in,
	// card switch
	input  wire logic        i_card_switch_in,
	// analog supply sense
	input  wire logic        i_supply_under,
	input  wire logic        i_supply_at_level,
	// card outputs as returned by the pads
	input  wire logic        i_card_clock_sense,
	input  wire logic        i_card_reset_sense,
	// three data channels: 0 data, 1 aux one, 2 aux two
	input  wire logic [2:0]  i_host_chan_in,
	input  wire logic [2:0]  i_card_chan_in,
	output logic      [2:0]  o_host_chan_o,
	output logic      [2:0]  o_host_chan_oe,
	output logic      [2:0]  o_card_chan_o,
	output logic      [2:0]  o_card_chan_oe,
	// card supply and control
	output logic             o_supply_enable,
	output logic             o_supply_5v,
	output logic             o_supply_discharge,
	output logic             o_card_clock,
	output logic             o_card_reset,
	// status
	output logic             o_ready_n,
	output logic             o_fault_n,
	output logic             o_card_present_n,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp
);
	typedef struct packed {
		card_seq_pkg::mode_t           mode;
		logic                          req_n;
		logic                          vsel;
		logic                          rdy;
		logic [card_seq_pkg::CNT_W-1:0] ramp;
		logic [card_seq_pkg::CNT_W-1:0] under;
		logic [card_seq_pkg::CNT_W-1:0] rmis;
		logic [card_seq_pkg::CNT_W-1:0] cmis;
		logic [card_seq_pkg::CNT_W-1:0] deb;
		logic [card_seq_pkg::CNT_W-1:0] rem;
		logic                          present;
		logic                          reduced;
		logic                          wr_pend;
		logic [7:0]                    addr;
		logic [31:0]                   rdata;
	} state_t;

	state_t s_q;
	state_t s_d;

	logic       sel_n;
	logic       sw_active;
	logic       chan_en;
	logic       idle_low;
	logic       addr_ok;
	card_seq_pkg::chan_sense_t sense [3];
	card_seq_pkg::chan_drive_t drive [3];

	// reduced variant ties select to the request, normally-open switch
	assign sel_n     = s_q.reduced ? i_power_request_n
		: i_io_select_n;
	assign sw_active = (s_q.reduced ? 1'b0 : i_switch_polarity)
		? i_card_switch_in : !i_card_switch_in;
	assign chan_en   = (s_q.mode == card_seq_pkg::ST_ACTIVE) && s_q.rdy
		&& !sel_n;
	assign idle_low  = s_q.mode != card_seq_pkg::ST_ACTIVE;
	assign addr_ok   = hsel && hready && (htrans == card_seq_pkg::HTRANS_NONSEQ
		|| htrans == card_seq_pkg::HTRANS_SEQ);

	// ************************************************************
	// sequencer
	// ************************************************************
	always_comb begin
		s_d = s_q;
		s_d.req_n = i_power_request_n;
		case (s_q.mode)
			card_seq_pkg::ST_IDLE: begin
				s_d.rdy = 1'b0;
				if (!i_power_request_n && s_q.req_n) begin
					s_d.mode = card_seq_pkg::ST_ACTIVE;
					s_d.vsel = i_voltage_select;
					s_d.ramp = '0;
				end
			end
			card_seq_pkg::ST_ACTIVE: begin
				if (i_power_request_n) begin
					s_d.mode = card_seq_pkg::ST_IDLE;
					s_d.rdy  = 1'b0;
				end else begin
					if (!s_q.rdy && i_supply_at_level) begin
						if (s_q.ramp >= card_seq_pkg::CNT_W'(RAMP_CYC))
							s_d.rdy = 1'b1;
						else
							s_d.ramp = s_q.ramp + 1'b1;
					end
					s_d.under = i_supply_under ? s_q.under + 1'b1 : '0;
					s_d.rmis = (s_q.rdy && i_card_reset_sense != i_host_reset_in)
						? s_q.rmis + 1'b1 : '0;
					s_d.cmis = (s_q.rdy && i_card_clock_sense != i_host_clock_in)
						? s_q.cmis + 1'b1 : '0;
					if (s_q.under >= card_seq_pkg::CNT_W'(card_seq_pkg::UNDER_CYC
						- 1))
						s_d.mode = card_seq_pkg::ST_ALARM;
					if (s_q.rmis >= card_seq_pkg::CNT_W'(card_seq_pkg::MISMATCH_CYC))
						s_d.mode = card_seq_pkg::ST_ALARM;
					if (s_q.cmis >= card_seq_pkg::CNT_W'(card_seq_pkg::MISMATCH_CYC))
						s_d.mode = card_seq_pkg::ST_ALARM;
				end
			end
			card_seq_pkg::ST_ALARM: begin
				s_d.rdy = 1'b0;
				if (i_power_request_n)
					s_d.mode = card_seq_pkg::ST_IDLE;
			end
			default: s_d.mode = card_seq_pkg::ST_IDLE;
		endcase
		if (s_d.mode != card_seq_pkg::ST_ACTIVE) begin
			s_d.under = '0;
			s_d.rmis  = '0;
			s_d.cmis  = '0;
			s_d.rdy   = 1'b0;
		end
		// debounce: long wait to report, short wait to withdraw
		if (sw_active) begin
			s_d.rem = '0;
			if (s_q.deb >= card_seq_pkg::CNT_W'(DEBOUNCE_CYC))
				s_d.present = 1'b1;
			else
				s_d.deb = s_q.deb + 1'b1;
		end else begin
			s_d.deb = '0;
			if (s_q.rem >= card_seq_pkg::CNT_W'(card_seq_pkg::REMOVE_CYC / 2))
				s_d.present = 1'b0;
			else
				s_d.rem = s_q.rem + 1'b1;
		end
		// bus: one wait-free data phase
		s_d.wr_pend = addr_ok && hwrite;
		s_d.addr    = haddr[7:0];
		if (s_q.wr_pend && s_q.addr == card_seq_pkg::CTRL_OFS)
			s_d.reduced = hwdata[card_seq_pkg::CTRL_REDUCED_BIT];
		if (addr_ok && !hwrite) begin
			s_d.rdata = '0;
			if (haddr[7:0] == card_seq_pkg::CTRL_OFS)
				s_d.rdata[card_seq_pkg::CTRL_REDUCED_BIT] = s_q.reduced;
			else if (haddr[7:0] == card_seq_pkg::STATUS_OFS)
				s_d.rdata[5:0] = {s_q.present, s_q.vsel, s_q.rdy, 1'b0,
					s_q.mode};
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s_q <= '0;
			s_q.mode  <= card_seq_pkg::ST_IDLE;
			s_q.req_n <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// ************************************************************
	// data channels
	// ************************************************************
	for (genvar g = 0; g < 3; g++) begin : g_chan
		assign sense[g] = '{host_in: i_host_chan_in[g],
			card_in: i_card_chan_in[g]};
		chan_arbiter u_arb (
			.i_mclk   (i_mclk),
			.i_rst_n  (i_rst_n),
			.i_enable (chan_en),
			.i_idle_low (idle_low),
			.i_sense  (sense[g]),
			.o_drive  (drive[g])
		);
		assign o_host_chan_o[g]  = drive[g].host_o;
		assign o_host_chan_oe[g] = drive[g].host_oe;
		assign o_card_chan_o[g]  = drive[g].card_o;
		assign o_card_chan_oe[g] = drive[g].card_oe;
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign o_supply_enable    = s_q.mode == card_seq_pkg::ST_ACTIVE;
	assign o_supply_5v        = s_q.vsel;
	assign o_supply_discharge = !o_supply_enable;
	assign o_card_clock = s_q.rdy && o_supply_enable
		&& i_host_clock_in;
	assign o_card_reset = s_q.rdy && o_supply_enable
		&& i_host_reset_in;
	assign o_ready_n        = !s_q.rdy;
	assign o_fault_n        = s_q.mode != card_seq_pkg::ST_ALARM;
	assign o_card_present_n = !s_q.present;
	assign hrdata    = s_q.rdata;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	a_clk_gated: assert property (@(posedge i_mclk)
		disable iff (!i_rst_n) o_ready_n |-> !o_card_clock && !o_card_reset)
		else $error("card clock or reset before ready");
	a_vsel_hold: assert property (@(posedge i_mclk)
		disable iff (!i_rst_n)
		s_q.mode == card_seq_pkg::ST_ACTIVE ##1
		s_q.mode == card_seq_pkg::ST_ACTIVE |-> $stable(o_supply_5v))
		else $error("voltage select changed while active");
	a_under_alarm: assert property (@(posedge i_mclk)
		disable iff (!i_rst_n)
		s_q.mode == card_seq_pkg::ST_ACTIVE && !i_power_request_n
		&& s_q.under >= card_seq_pkg::CNT_W'(card_seq_pkg::UNDER_CYC - 1)
		|=> s_q.mode == card_seq_pkg::ST_ALARM)
		else $error("under-range did not raise alarm");
	a_alarm_exit: assert property (@(posedge i_mclk)
		disable iff (!i_rst_n)
		s_q.mode == card_seq_pkg::ST_ALARM && !i_power_request_n
		|=> s_q.mode == card_seq_pkg::ST_ALARM)
		else $error("alarm left while request low");
	a_fault_out: assert property (@(posedge i_mclk)
		disable iff (!i_rst_n)
		s_q.mode == card_seq_pkg::ST_ACTIVE && !i_power_request_n
		&& s_q.cmis >= card_seq_pkg::CNT_W'(card_seq_pkg::MISMATCH_CYC)
		|=> !o_fault_n)
		else $error("fault output not low after clock mismatch");
	a_discharge: assert property (@(posedge i_mclk)
		disable iff (!i_rst_n)
		o_fault_n == 1'b0 |-> o_supply_discharge && o_ready_n)
		else $error("supply not discharged in alarm");
	a_chan_sel: assert property (@(posedge i_mclk)
		disable iff (!i_rst_n)
		sel_n && !idle_low |-> o_card_chan_o == 3'h7
		&& o_card_chan_oe == 3'h7 && o_host_chan_oe == 3'h0)
		else $error("channel active while deselected");
	a_activate: assert property (@(posedge i_mclk)
		disable iff (!i_rst_n)
		s_q.mode == card_seq_pkg::ST_IDLE && s_q.req_n && !i_power_request_n
		|=> o_supply_enable)
		else $error("activation missed");

	c_ready: cover property (@(posedge i_mclk) $fell(o_ready_n));
	c_alarm: cover property (@(posedge i_mclk) $fell(o_fault_n));
	c_card: cover property (@(posedge i_mclk) $fell(o_card_present_n));
endmodule // card_interface_sequencer
`default_nettype wire

// *** card_seq_pkg.sv ***
/*
 * shared constants and carrier types for the card interface sequencer.
 * assumes a single 250 MHz clock; pins are sampled synchronously.
 */
`default_nettype none
package card_seq_pkg;
	// ************************************************************
	// clock and timing
	// ************************************************************
	localparam int CLK_MHZ          = 250;
	localparam int UNDER_MIN_NS     = 5000;
	localparam int UNDER_CYC        = (UNDER_MIN_NS * CLK_MHZ) / 1000;
	localparam int MISMATCH_US      = 4;
	localparam int MISMATCH_CYC     = MISMATCH_US * CLK_MHZ;
	localparam int DEBOUNCE_MS      = 40;
	localparam int DEBOUNCE_CYC     = DEBOUNCE_MS * 1000 * CLK_MHZ;
	localparam int REMOVE_US        = 50;
	localparam int REMOVE_CYC       = REMOVE_US * CLK_MHZ;
	localparam int CNT_W            = 24;
	localparam int RAMP_CYC_DEF     = 1000;

	// ************************************************************
	// bus map (all offsets chosen here)
	// ************************************************************
	localparam logic [7:0] CTRL_OFS   = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_SEQ    = 2'h3;
	localparam int CTRL_REDUCED_BIT = 0;
	localparam int CTRL_W           = 1;

	typedef enum logic [1:0] {ST_IDLE, ST_ACTIVE, ST_ALARM} mode_t;
	typedef enum logic [1:0] {DIR_IDLE, DIR_H2C, DIR_C2H} dir_t;

	// one open-drain style data channel seen from the device
	typedef struct packed {
		logic host_o;
		logic host_oe;
		logic card_o;
		logic card_oe;
	} chan_drive_t;

	typedef struct packed {
		logic host_in;
		logic card_in;
	} chan_sense_t;
endpackage
`default_nettype wire

// *** card_pads_model.sv ***
/*
 * partner model: analog card supply sense and the card-side pads.
 * assumes the sequencer's card outputs and a few fault controls
 * from the bench; the data channel lines have pull-ups as on the real contacts.
 */
`timescale 1ns/100ps
`default_nettype none
module card_pads_model #(
	parameter int RISE_CYC = 6
) (
	// clock
	input  wire logic       i_mclk,
	// from the sequencer
	input  wire logic       i_supply_enable,
	input  wire logic       i_card_clock,
	input  wire logic       i_card_reset,
	input  wire logic [2:0] i_card_chan_o,
	input  wire logic [2:0] i_card_chan_oe,
	// bench controls
	input  wire logic [2:0] i_card_low,
	input  wire logic       i_force_under,
	input  wire logic       i_short_clock,
	input  wire logic       i_short_reset,
	// to the sequencer
	output logic            o_supply_under,
	output logic            o_supply_at_level,
	output logic            o_card_clock_sense,
	output logic            o_card_reset_sense,
	output logic      [2:0] o_card_chan_in
);
	// ************************************************************
	// supply ramp: slow rise, instant collapse when switched off
	// ************************************************************
	int rise_q = 0;
	always_ff @(posedge i_mclk) begin
		if (!i_supply_enable)
			rise_q <= 0;
		else if (rise_q < RISE_CYC)
			rise_q <= rise_q + 1;
	end
	assign o_supply_at_level = (rise_q == RISE_CYC) && !i_force_under;
	assign o_supply_under    = i_force_under;
	// ************************************************************
	// pads: a short pins the clock or reset contact low
	// ************************************************************
	assign o_card_clock_sense = i_short_clock ? 1'b0 : i_card_clock;
	assign o_card_reset_sense = i_short_reset ? 1'b0 : i_card_reset;
	// open drain with pull-up: released lines read high
	assign o_card_chan_in = ~(i_card_low | (i_card_chan_oe & ~i_card_chan_o));
endmodule // card_pads_model
`default_nettype wire

// *** card_interface_sequencer_tb_top.sv ***
/*
 * self-checking bench for the card interface sequencer.
 * assumes card_pads_model on the card side; bench plays the host.
 */
`timescale 1ns/100ps
`default_nettype none
module card_interface_sequencer_tb_top;
	logic        mclk, rst_n, pwr_n, sel_n, vsel, pol, hrst, hclk, sw;
	logic        under, at_lvl, clk_s, rst_s, f_under, short_clk, short_rst;
	logic [2:0]  host_low, card_low, host_in, card_in, h_o, h_oe, c_o, c_oe;
	logic        sup_en, sup5, dis, c_clk, c_rst, rdy_n, flt_n, card_switch_in_n;
	logic        hsel, hwrite, hreadyout, hresp;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] haddr, hwdata, hrdata, rd;
	int          n_errors, n_checks, i;
	// host pins are open drain with pull-ups
	assign host_in = ~(host_low | (h_oe & ~h_o));
	card_interface_sequencer #(.DEBOUNCE_CYC(20), .RAMP_CYC(4)) uut (
		.i_mclk(mclk), .i_rst_n(rst_n), .i_power_request_n(pwr_n),
		.i_io_select_n(sel_n), .i_voltage_select(vsel),
		.i_switch_polarity(pol), .i_host_reset_in(hrst),
		.i_host_clock_in(hclk), .i_card_switch_in(sw),
		.i_supply_under(under), .i_supply_at_level(at_lvl),
		.i_card_clock_sense(clk_s), .i_card_reset_sense(rst_s),
		.i_host_chan_in(host_in), .i_card_chan_in(card_in),
		.o_host_chan_o(h_o), .o_host_chan_oe(h_oe), .o_card_chan_o(c_o),
		.o_card_chan_oe(c_oe), .o_supply_enable(sup_en), .o_supply_5v(sup5),
		.o_supply_discharge(dis), .o_card_clock(c_clk), .o_card_reset(c_rst),
		.o_ready_n(rdy_n), .o_fault_n(flt_n), .o_card_present_n(card_switch_in_n),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp));
	card_pads_model pads (
		.i_mclk(mclk), .i_supply_enable(sup_en), .i_card_clock(c_clk),
		.i_card_reset(c_rst), .i_card_chan_o(c_o), .i_card_chan_oe(c_oe),
		.i_card_low(card_low), .i_force_under(f_under),
		.i_short_clock(short_clk), .i_short_reset(short_rst),
		.o_supply_under(under),
		.o_supply_at_level(at_lvl), .o_card_clock_sense(clk_s),
		.o_card_reset_sense(rst_s), .o_card_chan_in(card_in));
	// ************************************************************
	// shared tasks
	// ************************************************************
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		hsize <= 3'h2;
		htrans <= card_seq_pkg::HTRANS_NONSEQ;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		rd = hrdata;
		chk(hresp, 0);
	endtask
	task automatic complete_run;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// ************************************************************
	// scenarios
	// ************************************************************
	task automatic idle_test;
		chk({rdy_n, flt_n, card_switch_in_n, dis, sup_en}, 5'h1e);
		chk({c_clk, c_rst, card_in[0]}, 0);
		ahb(0, 32'h40, 0);
		chk(rd, 0);
		ahb(0, 32'h04, 0);
		chk(rd[1:0], 0);
		$display("idle test done");
	endtask
	task automatic switch_test;
		for (int p = 1; p >= 0; p--) begin
			pol <= p[0];
			sw <= ~p[0];
			cyc(30);
			for (i = 0; i < 12500 && card_switch_in_n !== 1'b1; i++) cyc(1);
			sw <= p[0];
			cyc(10);
			chk(card_switch_in_n, 1);
			cyc(20);
			chk(card_switch_in_n, 0);
			sw <= ~p[0];
			for (i = 0; i < 12500 && card_switch_in_n !== 1'b1; i++) cyc(1);
			chk(card_switch_in_n, 1);
			sw <= p[0];
			cyc(30);
		end
		$display("switch test done");
	endtask
	task automatic activate(input logic v);
		vsel <= v;
		sel_n <= 1'b0;
		pwr_n <= 1'b0;
		hclk <= 1'b1;
		hrst <= 1'b1;
		cyc(2);
		vsel <= ~v;
		chk({sup_en, dis, c_clk, c_rst, rdy_n}, 5'h11);
		chk(h_oe & ~h_o, 0);
		for (i = 0; i < 50 && rdy_n !== 1'b0; i++) cyc(1);
		chk({rdy_n, c_clk, c_rst}, 3'h3);
		hclk <= 1'b0;
		cyc(1);
		chk(c_clk, 0);
		ahb(0, 32'h04, 0);
		chk({rd[4], rd[1:0]}, {v, 2'h1});
		chk(sup5, v);
	endtask
	task automatic chan_test;
		activate(0);
		host_low[0] <= 1'b1;
		cyc(3);
		chk(card_in[0], 0);
		card_low[0] <= 1'b1;
		cyc(3);
		host_low[0] <= 1'b0;
		cyc(3);
		chk(host_in[0], 1);
		card_low[0] <= 1'b0;
		cyc(3);
		chk({host_in, card_in}, 6'h3f);
		card_low[2] <= 1'b1;
		cyc(3);
		chk(host_in[2], 0);
		card_low[2] <= 1'b0;
		hclk <= 1'b1;
		sel_n <= 1'b1;
		cyc(3);
		chk({c_oe, c_o, h_oe}, 9'h1f8);
		chk({sup_en, c_clk, rdy_n}, 3'h6);
		pwr_n <= 1'b1;
		cyc(5);
		$display("channel test done");
	endtask
	task automatic fault_test;
		activate(1);
		f_under <= 1'b1;
		for (i = 0; i < 1500 && flt_n !== 1'b0; i++) cyc(1);
		chk(i > 1200, 1);
		chk({flt_n, rdy_n, dis}, 3'h3);
		f_under <= 1'b0;
		cyc(20);
		chk(flt_n, 0);
		pwr_n <= 1'b1;
		cyc(5);
		chk({flt_n, c_clk}, 2'h2);
		activate(0);
		hclk <= 1'b1;
		short_clk <= 1'b1;
		for (i = 0; i < 2000 && flt_n !== 1'b0; i++) cyc(1);
		chk({flt_n, rdy_n}, 2'h1);
		short_clk <= 1'b0;
		pwr_n <= 1'b1;
		cyc(5);
		activate(1);
		short_rst <= 1'b1;
		for (i = 0; i < 2000 && flt_n !== 1'b0; i++) cyc(1);
		chk({flt_n, rdy_n}, 2'h1);
		short_rst <= 1'b0;
		pwr_n <= 1'b1;
		cyc(5);
		$display("fault test done");
	endtask
	task automatic reduced_test;
		ahb(1, 32'h00, 32'h1);
		ahb(0, 32'h00, 0);
		chk(rd, 1);
		sel_n <= 1'b1;
		pwr_n <= 1'b0;
		for (i = 0; i < 50 && rdy_n !== 1'b0; i++) cyc(1);
		host_low[1] <= 1'b1;
		cyc(3);
		chk(card_in[1], 0);
		host_low[1] <= 1'b0;
		pwr_n <= 1'b1;
		cyc(5);
		ahb(1, 32'h00, 32'h0);
		$display("reduced test done");
	endtask
	// ************************************************************
	// clock, watchdog, main sequence
	// ************************************************************
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	initial begin
		#400000;
		n_errors++;
		complete_run();
	end
	initial begin
		{rst_n, sel_n, vsel, pol, hrst, hclk, sw, f_under} = 0;
		{short_clk, short_rst} = 0;
		{host_low, card_low, hsel, hwrite, htrans} = 0;
		{haddr, hwdata, hsize} = 0;
		pwr_n = 1'b1;
		repeat (5) @(posedge mclk);
		rst_n <= 1'b1;
		cyc(2);
		idle_test();
		switch_test();
		chan_test();
		fault_test();
		reduced_test();
		complete_run();
	end
endmodule // card_interface_sequencer_tb_top
`default_nettype wire
